// File: hdl/phy_cfg_params.svh
// constants of the strap control block
// Function
// - crossover auto-select defaults on; strap or control bit 15 change it
// - force-crossover bit swaps pairs regardless of negotiation or auto-select
// - automatic crossover is idle while speed and duplex are forced
// - crossover switching times come from a random seed
// - address straps share collision pin and receive data bits 0 to 3
// - strapped address lands in control bits 4:0 at every reset
// - answer management only at own address; system keeps addresses unique
// - strapped address zero isolates; written address zero does not
// - unstrapped address defaults to 00001 through weak pulls
// - basic control bit 10 also selects isolate mode
// - isolated: ignore transmit inputs, float receive side and clock outputs
// - isolated: management reads and writes keep working
// - isolated: media sends idles or link pulses but no packet data
// - isolated: negotiation and receive link keep running
// - indicator mode from control bit 5 or strap: 1 link, 0 link plus blink
// - 10 Mb/s link after seven pulses or a good packet; loss timer drops
// - indicator polarity follows negotiation strap: low strap active high
// - direct indicator register drives the pin; reads never show the pin
// - full duplex: no collision, carrier sense only from receive
// - half duplex: carrier sense from transmit and receive
// - parallel detection always resolves to half duplex
// - basic control bit 14 loops transmit to receive, mutes media, status bit 3
// - negotiation strap sets advertised abilities in bits 8:5
`ifndef PHY_CFG_PARAMS_SVH
`define PHY_CFG_PARAMS_SVH

// register offsets on the management bus
`define REG_BASIC_CONTROL   5'h00
`define REG_ADVERTISEMENT   5'h04
`define REG_STATUS_SUMMARY  5'h10
`define REG_INDICATOR_DIR   5'h18
`define REG_PHY_CONTROL     5'h19

// basic control fields
`define BC_SOFT_RESET       15
`define BC_LOOPBACK         14
`define BC_SPEED100         13
`define BC_AN_ENABLE        12
`define BC_ISOLATE          10
`define BC_AN_RESTART       9
`define BC_FULL_DUPLEX      8
`define BC_RESET_VAL        16'h3100

// phy control fields
`define PC_MDIX_EN          15
`define PC_FORCE_XOVER      14
`define PC_INDICATOR_MODE_CFG          5
`define PC_ADDR_LSB         0
`define PC_RESET_VAL        16'h8021

// advertisement fields
`define ADV_ABIL_LSB        5
`define ADV_ABIL_HALF       4'h5
`define ADV_ABIL_ALL        4'hF
`define ADV_RESET_VAL       16'h01E1

// status summary fields
`define ST_LINK             0
`define ST_SPEED10          1
`define ST_FULL             2
`define ST_LOOPBACK         3
`define ST_AN_DONE          4

// indicator direct control fields
`define IND_OVERRIDE        4
`define IND_VALUE           1
`define IND_RESET_VAL       16'h0000

// addressing and framing
`define ADDR_DEFAULT        5'h01
`define PREAMBLE_ONES       6'd32
`define HDR_BITS            5'd13
`define DATA_BITS           5'd16
`define NLP_FOR_LINK        3'd7

// timing
`define CLK_HZ              10000000
`define MDIX_SLOT_US        1000
`define MDIX_SLOT_CYC       (`MDIX_SLOT_US * (`CLK_HZ / 1000000))
`define BLINK_MS            50
`define BLINK_CYC           (`BLINK_MS * (`CLK_HZ / 1000))
`define LFSR_SEED           16'hACE1

`endif

// File: hdl/phy_cfg_pkg.sv
// types of the strap control block
package phy_cfg_pkg;
  typedef enum logic [3:0] {
    MG_PRE  = 4'b0001,
    MG_HDR  = 4'b0010,
    MG_TA   = 4'b0100,
    MG_DATA = 4'b1000
  } mgmt_state_t;
endpackage

// File: hdl/phy_config_strap_control.sv
// configuration, strap latching, isolate, loopback, duplex and indicator control
`timescale 1ns/100ps
`include "phy_cfg_params.svh"
module phy_config_strap_control #(
  parameter int unsigned MDIX_SLOT_CYC = `MDIX_SLOT_CYC,
  parameter int unsigned BLINK_CYC     = `BLINK_CYC
) (
  input  wire logic       SYS_CLK,      // device clock, 10 MHz
  input  wire logic       NRST,         // async reset, active low
  input  wire logic       MDC,          // management clock, sampled
  input  wire logic       MDIO_IN,      // management data in
  output logic            MDIO_OUT,     // management data out
  output logic            MDIO_OE_N,    // low while driving
  input  wire logic [3:0] TXD,          // mii transmit data
  input  wire logic       TX_EN,        // mii transmit enable
  input  wire logic       TXCLK_GEN,    // transmit clock from datapath
  output logic            TX_CLK_OUT,   // mii transmit clock
  output logic            TX_CLK_OE_N,  // low while driving
  input  wire logic [3:0] RXD_IN,       // rxd pins, address strap
  output logic [3:0]      RXD_OUT,      // mii receive data
  output logic            RXD_OE_N,     // low while driving
  input  wire logic       COL_IN,       // col pin, address strap bit 0
  output logic            COL_OUT,      // mii collision
  output logic            COL_OE_N,     // low while driving
  input  wire logic       CRS_IN,       // crs pin, indicator mode strap
  output logic            CRS_OUT,      // mii carrier sense
  output logic            CRS_OE_N,     // low while driving
  input  wire logic       RX_ER_IN,     // rx_er pin, crossover enable strap
  output logic            RX_ER_OUT,    // mii receive error
  output logic            RX_ER_OE_N,   // low while driving
  output logic            RX_DV_OUT,    // mii receive data valid
  output logic            RX_DV_OE_N,   // low while driving
  input  wire logic       LED_IN,       // indicator pin, negotiation strap
  output logic            LED_OUT,      // indicator drive level
  output logic            LED_OE_N,     // low while driving
  input  wire logic [3:0] DP_RXD,       // receive data from datapath
  input  wire logic       DP_RX_DV,     // receive valid from datapath
  input  wire logic       DP_RX_ER,     // receive error from datapath
  input  wire logic       DP_RX_ACT,    // receive activity level
  input  wire logic       SD_100,       // 100 Mb/s signal detect
  input  wire logic       NLP_PULSE,    // normal link pulse seen
  input  wire logic       GOOD_PKT_10,  // valid 10 Mb/s packet seen
  input  wire logic       LINK_LOSS,    // link loss timer expired
  input  wire logic       AN_DONE,      // negotiation complete
  input  wire logic       AN_PARALLEL,  // resolved by parallel detection
  input  wire logic       AN_SPEED100,  // negotiated speed 100
  input  wire logic       AN_FULL,      // negotiated full duplex
  output logic            AN_ENABLE,    // negotiation enabled
  output logic            AN_RESTART,   // restart pulse
  output logic            MEDIA_TX_EN,  // packet data to media
  output logic            MDI_CROSSED,  // pairs swapped
  output logic            ISOLATED      // isolate mode active
);

  phy_cfg_pkg::mgmt_state_t state;
  logic        strap_done;
  logic        an0_strap;
  logic        addr_zero_strap;
  logic [15:0] basic_control_reg;
  logic [15:0] phy_control_reg;
  logic [15:0] advertisement_reg;
  logic [15:0] indicator_direct_reg;
  logic        mdc_q;
  logic        mdc_rise;
  logic [5:0]  pre_cnt;
  logic [4:0]  bit_cnt;
  logic [12:0] hdr;
  logic        is_read;
  logic [4:0]  reg_addr;
  logic [15:0] rd_shift;
  logic [15:0] wr_shift;
  logic        wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [12:0] next_hdr;
  logic        link10;
  logic [2:0]  nlp_cnt;
  logic        link;
  logic        speed100;
  logic        full_dup;
  logic        loopback;
  logic        tx_en_eff;
  logic        rx_act;
  logic        mdix_auto;
  logic        mdix_sel;
  logic [15:0] lfsr;
  logic [31:0] slot_cnt;
  logic [31:0] blink_cnt;
  logic        act_q;
  logic        led_level;
  logic        drive_mii;

  // management clock edge; inputs already synchronous
  assign mdc_rise = MDC & ~mdc_q;
  assign next_hdr = {hdr[11:0], MDIO_IN};

  // operating mode resolution
  assign AN_ENABLE = basic_control_reg[`BC_AN_ENABLE];
  assign loopback  = basic_control_reg[`BC_LOOPBACK];
  assign ISOLATED  = addr_zero_strap | basic_control_reg[`BC_ISOLATE];
  assign speed100  = AN_ENABLE ? AN_SPEED100 : basic_control_reg[`BC_SPEED100];
  // parallel detection cannot see full duplex, so it falls back to half
  assign full_dup  = AN_ENABLE ? (AN_FULL & ~AN_PARALLEL) : basic_control_reg[`BC_FULL_DUPLEX];
  assign link      = speed100 ? SD_100 : link10;
  assign tx_en_eff = TX_EN & ~ISOLATED;
  assign rx_act    = loopback ? tx_en_eff : DP_RX_ACT;
  assign drive_mii = strap_done & ~ISOLATED;

  // straps are taken on the first edge after release
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      strap_done      <= 1'b0;
      an0_strap       <= 1'b0;
      addr_zero_strap <= 1'b0;
    end else if (!strap_done) begin
      strap_done      <= 1'b1;
      an0_strap       <= LED_IN;
      addr_zero_strap <= ({RXD_IN, COL_IN} == 5'h00);
    end
  end

  // management serial framing
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      mdc_q     <= 1'b0;
      state     <= phy_cfg_pkg::MG_PRE;
      pre_cnt   <= 6'd0;
      bit_cnt   <= 5'd0;
      hdr       <= 13'h0000;
      is_read   <= 1'b0;
      reg_addr  <= 5'h00;
      rd_shift  <= 16'h0000;
      wr_shift  <= 16'h0000;
      wr_stb    <= 1'b0;
      wr_data   <= 16'h0000;
      MDIO_OUT  <= 1'b0;
      MDIO_OE_N <= 1'b1;
    end else begin
      mdc_q  <= MDC;
      wr_stb <= 1'b0;
      if (mdc_rise) begin
        case (state)
          phy_cfg_pkg::MG_PRE: begin
            if (MDIO_IN) begin
              if (pre_cnt != `PREAMBLE_ONES) begin
                pre_cnt <= pre_cnt + 6'd1;
              end
            end else if (pre_cnt == `PREAMBLE_ONES) begin
              state   <= phy_cfg_pkg::MG_HDR;
              bit_cnt <= 5'd0;
            end else begin
              pre_cnt <= 6'd0;
            end
          end
          phy_cfg_pkg::MG_HDR: begin
            hdr     <= next_hdr;
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == `HDR_BITS - 5'd1) begin
              bit_cnt  <= 5'd0;
              pre_cnt  <= 6'd0;
              reg_addr <= next_hdr[4:0];
              is_read  <= (next_hdr[11:10] == 2'b10);
              // only the own address is served, isolated or not
              if (next_hdr[12] && (next_hdr[11] ^ next_hdr[10]) &&
                  next_hdr[9:5] == phy_control_reg[4:0]) begin
                state <= phy_cfg_pkg::MG_TA;
              end else begin
                state <= phy_cfg_pkg::MG_PRE;
              end
            end
          end
          phy_cfg_pkg::MG_TA: begin
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == 5'd0) begin
              if (is_read) begin
                rd_shift  <= rd_data;
                MDIO_OUT  <= 1'b0;
                MDIO_OE_N <= 1'b0;
              end
            end else begin
              state    <= phy_cfg_pkg::MG_DATA;
              bit_cnt  <= 5'd0;
              MDIO_OUT <= rd_shift[15];
              rd_shift <= {rd_shift[14:0], 1'b0};
            end
          end
          phy_cfg_pkg::MG_DATA: begin
            bit_cnt  <= bit_cnt + 5'd1;
            wr_shift <= {wr_shift[14:0], MDIO_IN};
            MDIO_OUT <= rd_shift[15];
            rd_shift <= {rd_shift[14:0], 1'b0};
            if (bit_cnt == `DATA_BITS - 5'd1) begin
              state     <= phy_cfg_pkg::MG_PRE;
              MDIO_OUT  <= 1'b0;
              MDIO_OE_N <= 1'b1;
              wr_stb    <= ~is_read;
              wr_data   <= {wr_shift[14:0], MDIO_IN};
            end
          end
          default: begin
            state <= phy_cfg_pkg::MG_PRE;
          end
        endcase
      end
    end
  end

  // basic control; restart and soft reset bits self-clear
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      basic_control_reg <= `BC_RESET_VAL;
      AN_RESTART        <= 1'b0;
    end else begin
      AN_RESTART <= 1'b0;
      if (wr_stb && reg_addr == `REG_BASIC_CONTROL) begin
        basic_control_reg <= wr_data & ~16'h8200;
        AN_RESTART        <= wr_data[`BC_AN_RESTART];
      end
    end
  end

  // phy control; straps overwrite their fields once after reset
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      phy_control_reg <= `PC_RESET_VAL;
    end else if (!strap_done) begin
      phy_control_reg[`PC_MDIX_EN] <= RX_ER_IN;
      phy_control_reg[`PC_INDICATOR_MODE_CFG] <= CRS_IN;
      phy_control_reg[4:0]         <= {RXD_IN, COL_IN};
    end else if (wr_stb && reg_addr == `REG_PHY_CONTROL) begin
      // a written zero address changes matching only, never isolation
      phy_control_reg <= wr_data;
    end
  end

  // advertisement; abilities follow the negotiation strap
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      advertisement_reg <= `ADV_RESET_VAL;
    end else if (!strap_done) begin
      advertisement_reg[8:5] <= LED_IN ? `ADV_ABIL_ALL : `ADV_ABIL_HALF;
    end else if (wr_stb && reg_addr == `REG_ADVERTISEMENT) begin
      advertisement_reg <= wr_data;
    end
  end

  // indicator direct control, plain storage
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      indicator_direct_reg <= `IND_RESET_VAL;
    end else if (wr_stb && reg_addr == `REG_INDICATOR_DIR) begin
      indicator_direct_reg <= wr_data;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_data = 16'h0000;
    case (reg_addr)
      `REG_BASIC_CONTROL:  rd_data = basic_control_reg;
      `REG_ADVERTISEMENT:  rd_data = advertisement_reg;
      `REG_PHY_CONTROL:    rd_data = phy_control_reg;
      `REG_INDICATOR_DIR:  rd_data = indicator_direct_reg;
      `REG_STATUS_SUMMARY: begin
        rd_data[`ST_LINK]     = link;
        rd_data[`ST_SPEED10]  = ~speed100;
        rd_data[`ST_FULL]     = full_dup;
        rd_data[`ST_LOOPBACK] = loopback;
        rd_data[`ST_AN_DONE]  = AN_DONE;
      end
      default: rd_data = 16'h0000;
    endcase
  end

  // 10 Mb/s link; a set event wins over a same-cycle loss
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      link10  <= 1'b0;
      nlp_cnt <= 3'd0;
    end else if (GOOD_PKT_10) begin
      link10 <= 1'b1;
    end else if (NLP_PULSE) begin
      if (nlp_cnt == `NLP_FOR_LINK - 3'd1) begin
        link10 <= 1'b1;
      end else begin
        nlp_cnt <= nlp_cnt + 3'd1;
      end
    end else if (LINK_LOSS) begin
      link10  <= 1'b0;
      nlp_cnt <= 3'd0;
    end
  end

  // crossover hunt: random toggles per slot while no link; off when forced
  assign mdix_auto   = phy_control_reg[`PC_MDIX_EN] & AN_ENABLE;
  assign MDI_CROSSED = phy_control_reg[`PC_FORCE_XOVER] | (mdix_auto & mdix_sel);
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      lfsr     <= `LFSR_SEED;
      slot_cnt <= 32'h0000_0000;
      mdix_sel <= 1'b0;
    end else begin
      // free-running lfsr so the seed depends on elapsed time
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      if (slot_cnt == MDIX_SLOT_CYC - 1) begin
        slot_cnt <= 32'h0000_0000;
        if (mdix_auto && !link && lfsr[0]) begin
          mdix_sel <= ~mdix_sel;
        end
      end else begin
        slot_cnt <= slot_cnt + 32'h0000_0001;
      end
    end
  end

  // activity blink: one off then on half-period per restart
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      act_q     <= 1'b0;
      blink_cnt <= 32'h0000_0000;
    end else begin
      act_q <= tx_en_eff | DP_RX_ACT;
      if ((tx_en_eff | DP_RX_ACT) && !act_q) begin
        blink_cnt <= BLINK_CYC;
      end else if (blink_cnt != 32'h0000_0000) begin
        blink_cnt <= blink_cnt - 32'h0000_0001;
      end
    end
  end

  // indicator level, then polarity from the strap
  always_comb begin
    if (indicator_direct_reg[`IND_OVERRIDE]) begin
      led_level = indicator_direct_reg[`IND_VALUE];
    end else if (phy_control_reg[`PC_INDICATOR_MODE_CFG]) begin
      led_level = link;
    end else begin
      led_level = link & ~(blink_cnt > (BLINK_CYC / 2));
    end
  end

  // mii and indicator drivers; outputs float until straps are taken
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      RXD_OUT     <= 4'h0;
      RX_DV_OUT   <= 1'b0;
      RX_ER_OUT   <= 1'b0;
      CRS_OUT     <= 1'b0;
      COL_OUT     <= 1'b0;
      TX_CLK_OUT  <= 1'b0;
      MEDIA_TX_EN <= 1'b0;
      LED_OUT     <= 1'b0;
      LED_OE_N    <= 1'b1;
      RXD_OE_N    <= 1'b1;
      RX_DV_OE_N  <= 1'b1;
      RX_ER_OE_N  <= 1'b1;
      CRS_OE_N    <= 1'b1;
      COL_OE_N    <= 1'b1;
      TX_CLK_OE_N <= 1'b1;
    end else begin
      RXD_OUT     <= loopback ? TXD : DP_RXD;
      RX_DV_OUT   <= loopback ? tx_en_eff : DP_RX_DV;
      RX_ER_OUT   <= loopback ? 1'b0 : DP_RX_ER;
      CRS_OUT     <= rx_act | (~full_dup & tx_en_eff);
      COL_OUT     <= ~full_dup & ~loopback & tx_en_eff & DP_RX_ACT;
      TX_CLK_OUT  <= TXCLK_GEN;
      // idles and link pulses are the datapath's; only packet data is gated
      MEDIA_TX_EN <= tx_en_eff & ~loopback;
      LED_OUT     <= led_level ^ an0_strap;
      LED_OE_N    <= ~strap_done;
      RXD_OE_N    <= ~drive_mii;
      RX_DV_OE_N  <= ~drive_mii;
      RX_ER_OE_N  <= ~drive_mii;
      CRS_OE_N    <= ~drive_mii;
      COL_OE_N    <= ~drive_mii;
      TX_CLK_OE_N <= ~drive_mii;
    end
  end

endmodule

// File: testbench/mgmt_agent.sv
// management agent model driving clause-22 frames
`timescale 1ns/100ps
module mgmt_agent (
  input  wire logic   clk,      // device clock
  input  wire logic   md_out,   // device data out
  input  wire logic   md_oe_n,  // device drive, low active
  output logic        mdc,      // management clock
  output wire logic   mdio,     // resolved wire level
  output logic        rd_valid, // read word ready
  output logic [15:0] rd_data   // read word
);
  logic drv;
  logic val;
  // pull-up: a silent device reads ones
  assign mdio = !md_oe_n ? md_out : (drv ? val : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    val = 1'b1;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end
  // one period: three cycles low, three high
  task automatic mbit(input logic d, input logic en, output logic s);
    drv = en;
    val = d;
    mdc = 1'b0;
    repeat (3) @(posedge clk);
    #10 mdc = 1'b1;
    repeat (3) @(posedge clk);
    #10 s = mdio;
  endtask
  // sample after rise k shows the bit the device drives for rise k+1
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
    logic [31:0] hdr;
    logic        s;
    hdr = {2'b01, rd ? 2'b10 : 2'b01, pa, ra, rd ? 2'b11 : 2'b10, wd};
    for (int i = 0; i < 32; i++) mbit(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      mbit(hdr[i], !(rd && i < 18), s);
      if (i >= 1 && i <= 16) rd_data[i-1] = s;
    end
    drv = 1'b0;
    mdc = 1'b0;
    repeat (4) @(posedge clk);
    if (rd) begin
      #10 rd_valid = 1'b1;
      @(posedge clk);
      #10 rd_valid = 1'b0;
    end
  endtask
endmodule

// File: testbench/phy_cfg_props.sv
// port assertions of the strap control block
`timescale 1ns/100ps
module phy_cfg_props (
  input wire logic SYS_CLK,     // device clock
  input wire logic NRST,        // reset, low active
  input wire logic MDC,         // management clock
  input wire logic MDIO_OUT,    // management data out
  input wire logic MDIO_OE_N,   // drive, low active
  input wire logic TX_EN,       // mii transmit enable
  input wire logic TXCLK_GEN,   // transmit clock source
  input wire logic TX_CLK_OUT,  // mii transmit clock
  input wire logic TX_CLK_OE_N, // transmit clock drive
  input wire logic RXD_OE_N,    // receive data drive
  input wire logic COL_OUT,     // collision
  input wire logic COL_OE_N,    // collision drive
  input wire logic CRS_OUT,     // carrier sense
  input wire logic CRS_OE_N,    // carrier sense drive
  input wire logic RX_ER_OE_N,  // receive error drive
  input wire logic RX_DV_OE_N,  // receive valid drive
  input wire logic DP_RX_ACT,   // receive activity
  input wire logic MEDIA_TX_EN, // packet data to media
  input wire logic ISOLATED     // isolate mode
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // isolation floats every mii output
  a_iso_float: assert property (ISOLATED |=> RXD_OE_N && COL_OE_N && CRS_OE_N && RX_DV_OE_N)
    else $error("mii outputs driven while isolated");
  a_iso_clock: assert property (ISOLATED |=> TX_CLK_OE_N && RX_ER_OE_N)
    else $error("clock or error driven while isolated");
  a_drive_cause: assert property (!RXD_OE_N |-> !$past(ISOLATED))
    else $error("receive data driven after isolation");
  // media data only from a real transmit
  a_media_cause: assert property (MEDIA_TX_EN |-> $past(TX_EN) && !$past(ISOLATED))
    else $error("media transmit without cause");
  a_col_cause: assert property (COL_OUT |-> $past(TX_EN) && $past(DP_RX_ACT))
    else $error("collision without transmit and receive");
  a_crs_cause: assert property (CRS_OUT |-> $past(TX_EN) || $past(DP_RX_ACT))
    else $error("carrier sense without activity");
  // read bits change only while mdc is high
  a_mdio_turn: assert property ($fell(MDIO_OE_N) |-> !MDIO_OUT && MDC)
    else $error("turnaround bit wrong");
  a_mdio_hold: assert property (!MDIO_OE_N && !MDC |-> $stable(MDIO_OUT))
    else $error("read bit changed in low phase");
  a_mdio_release: assert property ($rose(MDIO_OE_N) |-> MDC)
    else $error("release off the clock rise");
  a_txclk_copy: assert property (!TX_CLK_OE_N |-> TX_CLK_OUT == $past(TXCLK_GEN))
    else $error("transmit clock not passed through");
  c_isolate: cover property (ISOLATED ##1 RXD_OE_N);
  c_collision: cover property (COL_OUT);
  c_read: cover property ($fell(MDIO_OE_N));
  c_media: cover property (MEDIA_TX_EN);
endmodule

// File: testbench/test_phy_config_strap_control.sv
// self-checking bench for the strap control block
`timescale 1ns/100ps
`include "phy_cfg_params.svh"
module test_phy_config_strap_control;
  logic        SYS_CLK, NRST, MDC, MDIO_IN, MDIO_OUT, MDIO_OE_N, TX_EN, TXCLK_GEN, COL_IN, CRS_IN;
  logic        RX_ER_IN, LED_IN, DP_RX_DV, DP_RX_ER, DP_RX_ACT, SD_100, NLP_PULSE, GOOD_PKT_10, LINK_LOSS;
  logic        AN_DONE, AN_PARALLEL, AN_SPEED100, AN_FULL, TX_CLK_OUT, TX_CLK_OE_N, RXD_OE_N, COL_OUT;
  logic        COL_OE_N, CRS_OUT, CRS_OE_N, RX_ER_OUT, RX_ER_OE_N, RX_DV_OUT, RX_DV_OE_N, LED_OUT, LED_OE_N;
  logic        AN_ENABLE, AN_RESTART, MEDIA_TX_EN, MDI_CROSSED, ISOLATED, rd_valid, prev;
  logic [3:0]  TXD, RXD_IN, DP_RXD, RXD_OUT;
  logic [4:0]  pa;
  logic [15:0] rd_data, expq[$];
  int          err_total, compares, n;
  phy_config_strap_control #(.MDIX_SLOT_CYC(16), .BLINK_CYC(20)) uut (.SYS_CLK, .NRST, .MDC, .MDIO_IN,
    .MDIO_OUT, .MDIO_OE_N, .TXD, .TX_EN, .TXCLK_GEN, .TX_CLK_OUT, .TX_CLK_OE_N, .RXD_IN, .RXD_OUT,
    .RXD_OE_N, .COL_IN, .COL_OUT, .COL_OE_N, .CRS_IN, .CRS_OUT, .CRS_OE_N, .RX_ER_IN, .RX_ER_OUT,
    .RX_ER_OE_N, .RX_DV_OUT, .RX_DV_OE_N, .LED_IN, .LED_OUT, .LED_OE_N, .DP_RXD, .DP_RX_DV, .DP_RX_ER,
    .DP_RX_ACT, .SD_100, .NLP_PULSE, .GOOD_PKT_10, .LINK_LOSS, .AN_DONE, .AN_PARALLEL, .AN_SPEED100,
    .AN_FULL, .AN_ENABLE, .AN_RESTART, .MEDIA_TX_EN, .MDI_CROSSED, .ISOLATED);
  mgmt_agent m (.clk(SYS_CLK), .md_out(MDIO_OUT), .md_oe_n(MDIO_OE_N), .mdc(MDC), .mdio(MDIO_IN),
    .rd_valid(rd_valid), .rd_data(rd_data));
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  // free-running transmit clock source
  always @(posedge SYS_CLK) TXCLK_GEN <= #10 ~TXCLK_GEN;
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // oldest expectation against each read word
  always @(posedge SYS_CLK) if (rd_valid) begin
    if (expq.size() == 0) chk(rd_data, 16'hxxxx);
    else chk(rd_data, expq.pop_front());
  end
  task automatic tick(input int k);
    repeat (k) @(posedge SYS_CLK);
    #10;
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    expq.push_back(exp);
    m.frame(1'b1, pa, ra, 16'h0000);
    tick(1);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    m.frame(1'b0, pa, ra, d);
    tick(1);
  endtask
  // straps {led, mode, xover, rxd, col}, held over the first edge
  task automatic do_reset(input logic [8:0] s);
    NRST = 1'b0;
    {LED_IN, CRS_IN, RX_ER_IN, RXD_IN, COL_IN} = s;
    tick(16);
    NRST = 1'b1;
    tick(2);
  endtask
  task automatic pulse_nlp;
    NLP_PULSE = 1'b1;
    tick(1);
    NLP_PULSE = 1'b0;
    tick(1);
  endtask
  initial begin
    repeat (100000) @(posedge SYS_CLK);
    err_total++;
    give_verdict();
  end
  initial begin
    {TX_EN, TXCLK_GEN, DP_RX_DV, DP_RX_ER, DP_RX_ACT, SD_100, NLP_PULSE, GOOD_PKT_10, LINK_LOSS} = '0;
    {AN_DONE, AN_PARALLEL, AN_SPEED100, AN_FULL, prev} = '0;
    TXD = 4'h0;
    DP_RXD = 4'h0;
    err_total = 0;
    compares = 0;
    pa = 5'h01;
    do_reset(9'b0_1_1_0000_1);
    void'($urandom(32'hf09a));
    rd(`REG_PHY_CONTROL, 16'h8021);
    rd(`REG_BASIC_CONTROL, 16'h3100);
    rd(`REG_ADVERTISEMENT, 16'h00A1);
    rd(`REG_INDICATOR_DIR, 16'h0000);
    rd(5'h1F, 16'h0000);
    pa = 5'h02;
    rd(`REG_PHY_CONTROL, 16'hFFFF);
    pa = 5'h01;
    $display("reset done");
    {AN_DONE, AN_FULL, AN_SPEED100, TX_EN} = 4'hF;
    {DP_RX_ER, DP_RXD} = {1'b1, 4'($urandom)};
    tick(2);
    chk({CRS_OUT, COL_OUT, MEDIA_TX_EN}, 3'b001);
    chk({RXD_OUT, RX_ER_OUT}, {DP_RXD, 1'b1});
    DP_RX_ACT = 1'b1;
    tick(2);
    chk({CRS_OUT, COL_OUT}, 2'b10);
    AN_PARALLEL = 1'b1;
    tick(2);
    chk({CRS_OUT, COL_OUT}, 2'b11);
    DP_RX_ACT = 1'b0;
    tick(2);
    chk({CRS_OUT, COL_OUT}, 2'b10);
    rd(`REG_STATUS_SUMMARY, 16'h0010);
    $display("duplex done");
    AN_DONE = 1'b0;
    DP_RX_ACT = 1'b1;
    wr(`REG_BASIC_CONTROL, 16'h4000);
    repeat (8) begin
      {TX_EN, TXD} = 5'($urandom);
      tick(2);
      chk({RX_DV_OUT, RXD_OUT, MEDIA_TX_EN, COL_OUT, AN_ENABLE, RX_ER_OUT, AN_RESTART}, {TX_EN, TXD, 5'b00000});
    end
    rd(`REG_STATUS_SUMMARY, 16'h000A);
    repeat (40) begin
      tick(5);
      chk(MDI_CROSSED, 16'h0000);
    end
    wr(`REG_PHY_CONTROL, 16'hC021);
    chk(MDI_CROSSED, 16'h0001);
    wr(`REG_PHY_CONTROL, 16'h8021);
    wr(`REG_BASIC_CONTROL, 16'h1000);
    n = 0;
    prev = MDI_CROSSED;
    repeat (320) begin
      tick(1);
      if (MDI_CROSSED !== prev) n++;
      prev = MDI_CROSSED;
    end
    chk(16'(n > 0), 16'h0001);
    $display("crossover done");
    TX_EN = 1'b1;
    SD_100 = 1'b1;
    wr(`REG_BASIC_CONTROL, 16'h2400);
    tick(2);
    chk({RXD_OE_N, COL_OE_N, CRS_OE_N, RX_ER_OE_N, RX_DV_OE_N, TX_CLK_OE_N, MEDIA_TX_EN}, 7'h7E);
    chk(ISOLATED, 16'h0001);
    rd(`REG_STATUS_SUMMARY, 16'h0001);
    rd(`REG_BASIC_CONTROL, 16'h2400);
    wr(`REG_BASIC_CONTROL, 16'h2000);
    tick(2);
    chk({RXD_OE_N, MEDIA_TX_EN}, 2'b01);
    $display("isolate done");
    {TX_EN, SD_100, DP_RX_ACT} = 3'b000;
    wr(`REG_BASIC_CONTROL, 16'h0000);
    repeat (6) pulse_nlp();
    rd(`REG_STATUS_SUMMARY, 16'h0002);
    chk(LED_OUT, 16'h0000);
    pulse_nlp();
    tick(1);
    chk(LED_OUT, 16'h0001);
    rd(`REG_STATUS_SUMMARY, 16'h0003);
    LINK_LOSS = 1'b1;
    tick(1);
    LINK_LOSS = 1'b0;
    tick(2);
    chk(LED_OUT, 16'h0000);
    GOOD_PKT_10 = 1'b1;
    tick(1);
    GOOD_PKT_10 = 1'b0;
    tick(2);
    chk(LED_OUT, 16'h0001);
    wr(`REG_PHY_CONTROL, 16'h8001);
    DP_RX_ACT = 1'b1;
    tick(3);
    chk(LED_OUT, 16'h0000);
    tick(15);
    chk(LED_OUT, 16'h0001);
    wr(`REG_INDICATOR_DIR, 16'h0010);
    tick(2);
    chk(LED_OUT, 16'h0000);
    rd(`REG_INDICATOR_DIR, 16'h0010);
    $display("indicator done");
    wr(`REG_PHY_CONTROL, 16'h8020);
    pa = 5'h00;
    chk(ISOLATED, 16'h0000);
    rd(`REG_PHY_CONTROL, 16'h8020);
    do_reset(9'b1_0_0_0000_0);
    chk({ISOLATED, LED_OUT, MDI_CROSSED, LED_OE_N}, 4'b1100);
    rd(`REG_PHY_CONTROL, 16'h0000);
    rd(`REG_ADVERTISEMENT, 16'h01E1);
    $display("strap done");
    give_verdict();
  end
endmodule
bind phy_config_strap_control phy_cfg_props u_props (.SYS_CLK, .NRST, .MDC, .MDIO_OUT, .MDIO_OE_N, .TX_EN,
  .TXCLK_GEN, .TX_CLK_OUT, .TX_CLK_OE_N, .RXD_OE_N, .COL_OUT, .COL_OE_N, .CRS_OUT, .CRS_OE_N, .RX_ER_OE_N,
  .RX_DV_OE_N, .DP_RX_ACT, .MEDIA_TX_EN, .ISOLATED);
